// [logic/crpt_top.sv]
// APB register block: byte CRC checker, analog/power controls, clock divider, test mux.
// Assumes APB master as usual; crystal tick arrives synchronous to i_ref_clk.
`timescale 1ns/1ps
`include "crpt_regs.svh"

module crpt_top
   import crpt_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter logic [15:0] CRC_POLY = 16'h1021
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_clock_out_ctl_pin,
   input wire logic i_xtal_tick,
   input wire logic [19:0] i_internal_monitor,
   input wire logic i_block_id_found,
   input wire logic i_block_id_code_hi,
   input wire logic i_block_id_code_lo,
   output logic o_clock_out_pin,
   output logic o_osc_run,
   output logic [1:0] o_input_gain,
   output logic [2:0] o_monitor_sel,
   output crpt_det_src_t o_detector_source,
   output logic o_analog_power_on,
   output logic o_digital_power_on,
   output logic o_digital_clk,
   output logic [4:0] o_test_out
);
   // Byte address of a register index
   function automatic logic [7:0] addr_of(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction : addr_of

   // Register contents
   logic [7:0] ext_port;
   logic [7:0] last_data;
   logic [7:0] analog_test_ctrl;
   logic [7:0] power_clock_ctrl;
   logic [7:0] test_output_select;
   logic transport_check_result;
   logic [15:0] accum;

   // Bus handling
   crpt_apb_state_t apb_state;
   logic access;
   logic done;
   logic wr_done;
   logic hit_data;
   logic hit_acc;
   logic hit_ctrl;
   logic mapped;
   logic can_go;
   logic checksum_clear;
   logic load_hi;
   logic load_lo;
   logic busy;
   logic pending;
   logic [31:0] next_rdata;

   // Clock divider
   logic [7:0] div_cnt;
   logic [2:0] div_code;
   logic div_bit;
   logic [4:0] next_test_out;
   logic [2:0] ts_code;

   crpt_byte_if #(.WIDTH(8)) fifo_in ();
   crpt_byte_if #(.WIDTH(8)) fifo_out ();

   // Address decode
   assign access = i_psel && i_penable;
   assign hit_data = (i_paddr == addr_of(`CRPT_IDX_CRC_DATA));
   assign hit_acc = (i_paddr == addr_of(`CRPT_IDX_ACC_UPPER)) ||
                    (i_paddr == addr_of(`CRPT_IDX_ACC_LOWER));
   assign hit_ctrl = (i_paddr == addr_of(`CRPT_IDX_CRC_CTRL));
   assign mapped = hit_data || hit_acc || hit_ctrl ||
                   (i_paddr == addr_of(`CRPT_IDX_EXT_PORT)) ||
                   (i_paddr == addr_of(`CRPT_IDX_CRC_RESULT)) ||
                   (i_paddr == addr_of(`CRPT_IDX_ANALOG)) ||
                   (i_paddr == addr_of(`CRPT_IDX_POWER)) ||
                   (i_paddr == addr_of(`CRPT_IDX_TEST_SEL));

   // Bytes still queued or in flight keep accumulator writes waiting, so that
   // a preload or clear never overtakes data already accepted
   assign busy = fifo_out.valid || pending;
   assign can_go = hit_data ? (fifo_in.ready && i_pwrite) || !i_pwrite :
                   (hit_acc || hit_ctrl) ? !(busy && i_pwrite) : 1'b1;
   assign done = access && o_pready;
   assign wr_done = done && i_pwrite && mapped && i_clk_en;

   assign checksum_clear = wr_done && hit_ctrl &&
      ((i_pwdata[7:0] & `CRPT_CLR_MASK) == `CRPT_CLR_VALUE);
   assign load_hi = wr_done && (i_paddr == addr_of(`CRPT_IDX_ACC_UPPER));
   assign load_lo = wr_done && (i_paddr == addr_of(`CRPT_IDX_ACC_LOWER));

   // Data port writes feed the FIFO; its ready holds pready low when full
   assign fifo_in.valid = wr_done && hit_data;
   assign fifo_in.data = i_pwdata[7:0];

   crpt_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_clk_en(i_clk_en),
      .s_in(fifo_in.sink),
      .s_out(fifo_out.source)
   );

   crpt_crc_engine #(
      .POLY(CRC_POLY)
   ) u_engine (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_clk_en(i_clk_en),
      .s_byte(fifo_out.sink),
      .i_clear(checksum_clear),
      .i_load_hi(load_hi),
      .i_load_lo(load_lo),
      .i_load_data(i_pwdata[7:0]),
      .o_accum(accum)
   );

   // APB handshake: one wait state, longer while the FIFO or engine is busy
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         apb_state <= CRPT_APB_IDLE;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else if (i_clk_en) begin
         case (apb_state)
            CRPT_APB_IDLE: begin
               o_pready <= 1'b0;
               o_pslverr <= 1'b0;
               if (i_psel && !i_penable) begin
                  apb_state <= CRPT_APB_WAIT;
               end
            end
            CRPT_APB_WAIT: begin
               if (access && (can_go || !mapped)) begin
                  o_pready <= 1'b1;
                  o_pslverr <= !mapped;
                  apb_state <= CRPT_APB_DONE;
               end
            end
            CRPT_APB_DONE: begin
               o_pready <= 1'b0;
               o_pslverr <= 1'b0;
               apb_state <= CRPT_APB_IDLE;
            end
            default: begin
               apb_state <= CRPT_APB_IDLE;
            end
         endcase
      end
   end

   // Read data mux; write-only registers read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (i_paddr)
         addr_of(`CRPT_IDX_CRC_DATA): next_rdata[7:0] = last_data;
         addr_of(`CRPT_IDX_CRC_RESULT): next_rdata[`CRPT_RESULT_BIT] = transport_check_result;
         addr_of(`CRPT_IDX_CRC_CTRL): next_rdata[`CRPT_CTRL_RESULT_BIT] = transport_check_result;
         addr_of(`CRPT_IDX_ACC_UPPER): next_rdata[7:0] = accum[15:8];
         addr_of(`CRPT_IDX_ACC_LOWER): next_rdata[7:0] = accum[7:0];
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured together with pready
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_clk_en) begin
         if (apb_state == CRPT_APB_WAIT && access && !i_pwrite && mapped) begin
            o_prdata <= next_rdata;
         end else if (apb_state == CRPT_APB_DONE) begin
            o_prdata <= 32'h0000_0000;
         end
      end
   end

   // Software-written control registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_port <= `CRPT_RST_BYTE;
         last_data <= `CRPT_RST_BYTE;
         analog_test_ctrl <= `CRPT_RST_BYTE;
         power_clock_ctrl <= `CRPT_RST_BYTE;
         test_output_select <= `CRPT_RST_BYTE;
      end else if (wr_done) begin
         case (i_paddr)
            addr_of(`CRPT_IDX_EXT_PORT): ext_port <= {3'b000, i_pwdata[4:0]};
            addr_of(`CRPT_IDX_CRC_DATA): last_data <= i_pwdata[7:0];
            addr_of(`CRPT_IDX_ANALOG): analog_test_ctrl <= {1'b0, i_pwdata[6:0]};
            addr_of(`CRPT_IDX_POWER): power_clock_ctrl <= i_pwdata[7:0] & 8'h77;
            addr_of(`CRPT_IDX_TEST_SEL): test_output_select <= i_pwdata[7:0] & 8'he0;
            default: ext_port <= ext_port;
         endcase
      end
   end

   // A byte popped this cycle lands in the accumulator next cycle
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pending <= 1'b0;
      end else if (i_clk_en) begin
         pending <= fifo_out.valid;
      end
   end

   // Mismatch whenever the accumulator is non-zero after the last byte;
   // follows preloads too, so a restored long check reports correctly
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         transport_check_result <= 1'b0;
      end else if (i_clk_en) begin
         transport_check_result <= (accum != `CRPT_RST_ACC);
      end
   end

   // Analog controls are registered from their register bits
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_input_gain <= 2'h0;
         o_monitor_sel <= 3'h0;
         o_detector_source <= CRPT_DET_COMPOSITE;
      end else if (i_clk_en) begin
         o_input_gain <= analog_test_ctrl[`CRPT_AN_GAIN_LSB +: 2];
         o_monitor_sel <= analog_test_ctrl[`CRPT_AN_MONITOR_LSB +: 3];
         if (analog_test_ctrl[`CRPT_AN_DIGTST_BIT]) begin
            o_detector_source <= CRPT_DET_TEST_DIGITAL;
         end else if (analog_test_ctrl[`CRPT_AN_DETSRC_BIT]) begin
            o_detector_source <= CRPT_DET_TEST_ANALOG;
         end else begin
            o_detector_source <= CRPT_DET_COMPOSITE;
         end
      end
   end

   // Power and oscillator enables
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_analog_power_on <= 1'b0;
         o_digital_power_on <= 1'b0;
         o_osc_run <= 1'b1;
      end else if (i_clk_en) begin
         o_analog_power_on <= power_clock_ctrl[`CRPT_PW_ANALOG_BIT];
         o_digital_power_on <= power_clock_ctrl[`CRPT_PW_DIGITAL_BIT];
         o_osc_run <= !i_clock_out_ctl_pin || power_clock_ctrl[`CRPT_PW_OSC_BIT];
      end
   end

   // Divider counts crystal ticks at twice 8.192 MHz; bit n gives 8.192 MHz / 2^n.
   // Counter only moves while the oscillator runs, so a stopped crystal freezes it.
   assign div_code = power_clock_ctrl[`CRPT_PW_DIV_LSB +: 3];
   assign div_bit = div_cnt[div_code];
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt <= 8'h00;
         o_clock_out_pin <= 1'b0;
      end else if (i_clk_en) begin
         if (i_xtal_tick && o_osc_run) begin
            div_cnt <= div_cnt + 8'h01;
         end
         o_clock_out_pin <= i_clock_out_ctl_pin ? 1'b0 : div_bit;
      end
   end

   // Digital section clock: parked high when powered down, restarts from high.
   // Toggling waits for the registered power flag, so the flag never rises on a low clock.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_digital_clk <= 1'b1;
      end else if (i_clk_en) begin
         if (!power_clock_ctrl[`CRPT_PW_DIGITAL_BIT] || !o_digital_power_on) begin
            o_digital_clk <= 1'b1;
         end else if (i_xtal_tick && o_osc_run) begin
            o_digital_clk <= !o_digital_clk;
         end
      end
   end

   // Test pin mux; unused select codes 0, 5 and 6 pass the external port through
   assign ts_code = test_output_select[`CRPT_TS_LSB +: 3];
   always_comb begin
      next_test_out = 5'h00;
      case (ts_code)
         3'h1: next_test_out = i_internal_monitor[4:0];
         3'h2: next_test_out = i_internal_monitor[9:5];
         3'h3: next_test_out = i_internal_monitor[14:10];
         3'h4: next_test_out = i_internal_monitor[19:15];
         3'h7: next_test_out = {i_block_id_found, i_block_id_code_hi,
                                i_block_id_code_lo, 2'b00};
         default: next_test_out = ext_port[4:0];
      endcase
   end

   // Test pins are registered to keep the outputs glitch free
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_test_out <= 5'h00;
      end else if (i_clk_en) begin
         o_test_out <= next_test_out;
      end
   end
endmodule : crpt_top

// [logic/crpt_regs.svh]
// Register indices, field positions and reset values of the CRC, power and test registers.
// Assumes APB byte addresses are four times the register index.
`ifndef CRPT_REGS_SVH
`define CRPT_REGS_SVH

// Register indices (byte address = index * 4)
`define CRPT_IDX_EXT_PORT 8'h0f
`define CRPT_IDX_CRC_CTRL 8'h28
`define CRPT_IDX_CRC_DATA 8'h29
`define CRPT_IDX_CRC_RESULT 8'h2a
`define CRPT_IDX_ACC_UPPER 8'h2b
`define CRPT_IDX_ACC_LOWER 8'h2c
`define CRPT_IDX_ANALOG 8'h30
`define CRPT_IDX_POWER 8'h31
`define CRPT_IDX_TEST_SEL 8'h32

// CRC control clear pattern: bits 7:5 set, bits 3:0 = 0001, bit 4 ignored
`define CRPT_CLR_MASK 8'hef
`define CRPT_CLR_VALUE 8'he1
`define CRPT_CTRL_RESULT_BIT 7
`define CRPT_RESULT_BIT 0

// Analog test fields
`define CRPT_AN_DETSRC_BIT 0
`define CRPT_AN_GAIN_LSB 1
`define CRPT_AN_MONITOR_LSB 3
`define CRPT_AN_DIGTST_BIT 6

// Power register fields
`define CRPT_PW_ANALOG_BIT 0
`define CRPT_PW_DIGITAL_BIT 1
`define CRPT_PW_OSC_BIT 2
`define CRPT_PW_DIV_LSB 4

// Test output select field
`define CRPT_TS_LSB 5

// Reset values
`define CRPT_RST_BYTE 8'h00
`define CRPT_RST_ACC 16'h0000

`endif

// [logic/crpt_pkg.sv]
// Types shared by the CRC, power and test register block.
// Assumes crpt_regs.svh supplies the numeric constants.
package crpt_pkg;
   typedef enum logic [1:0] {
      CRPT_DET_COMPOSITE,
      CRPT_DET_TEST_ANALOG,
      CRPT_DET_TEST_DIGITAL
   } crpt_det_src_t;

   typedef enum logic [1:0] {
      CRPT_APB_IDLE,
      CRPT_APB_WAIT,
      CRPT_APB_DONE
   } crpt_apb_state_t;
endpackage : crpt_pkg

// [logic/crpt_byte_if.sv]
// Byte stream carrier with valid/ready handshake between block modules.
// Assumes one clock domain; a byte moves when valid and ready are both high.
`timescale 1ns/1ps
interface crpt_byte_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface : crpt_byte_if

// [logic/crpt_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; the clock enable freezes all state.
`timescale 1ns/1ps
module crpt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   crpt_byte_if.sink s_in,
   crpt_byte_if.source s_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Honest full and empty flags derive from the fill count
   assign s_in.ready = (count != DEPTH[AW:0]);
   assign s_out.valid = (count != '0);
   assign s_out.data = mem[rd_ptr];
   assign push = s_in.valid && s_in.ready && i_clk_en;
   assign pop = s_out.valid && s_out.ready && i_clk_en;

   // Storage is not reset; only occupied slots are ever read
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= s_in.data;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : crpt_fifo

// [logic/crpt_crc_engine.sv]
// Byte-serial 16-bit CRC accumulator with clear and byte-wise preload.
// Assumes loads are only issued while the byte stream is idle.
`timescale 1ns/1ps
`include "crpt_regs.svh"
module crpt_crc_engine #(
   parameter logic [15:0] POLY = 16'h1021
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   crpt_byte_if.sink s_byte,
   input wire logic i_clear,
   input wire logic i_load_hi,
   input wire logic i_load_lo,
   input wire logic [7:0] i_load_data,
   output logic [15:0] o_accum
);
   // One byte folded in MSB first
   function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic [7:0] b);
      logic [15:0] c;
      c = acc ^ {b, 8'h00};
      for (int k = 0; k < 8; k++) begin
         c = c[15] ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc_step

   // Engine never stalls: one byte per enabled cycle
   assign s_byte.ready = 1'b1;

   // Software load beats the stream; the top keeps them apart anyway
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_accum <= `CRPT_RST_ACC;
      end else if (i_clk_en) begin
         if (i_clear) begin
            o_accum <= `CRPT_RST_ACC;
         end else if (i_load_hi) begin
            o_accum <= {i_load_data, o_accum[7:0]};
         end else if (i_load_lo) begin
            o_accum <= {o_accum[15:8], i_load_data};
         end else if (s_byte.valid) begin
            o_accum <= crc_step(o_accum, s_byte.data);
         end
      end
   end
endmodule : crpt_crc_engine

// [test/crpt_top_props.sv]
// Concurrent checks on the pins of the CRC, power and test register block.
// Assumes one clock domain and that the bench keeps the clock enable high.
`timescale 1ns/1ps
module crpt_top_props (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_clock_out_ctl_pin,
   input wire logic o_clock_out_pin,
   input wire logic o_osc_run,
   input wire logic [1:0] o_input_gain,
   input wire logic o_analog_power_on,
   input wire logic o_digital_power_on,
   input wire logic o_digital_clk
);
   logic [7:0] an_q;
   logic [7:0] pw_q;

   default clocking dc @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // Shadow of the last analog and power writes; pins are compared to it
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         an_q <= 8'h00;
         pw_q <= 8'h00;
      end else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'hc0) begin
         an_q <= i_pwdata[7:0];
      end else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'hc4) begin
         pw_q <= i_pwdata[7:0];
      end
   end

   function automatic logic f_mapped(input logic [7:0] a);
      return a inside {8'h3c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0, 8'hc0, 8'hc4, 8'hc8};
   endfunction : f_mapped

   // Completion edge of a transfer, then the two edges the pins lag by
   sequence s_done(logic [7:0] a, logic w);
      i_psel && i_penable && o_pready && (i_pwrite == w) && (i_paddr == a);
   endsequence
   sequence s_settle;
      i_clk_en ##1 i_clk_en ##1 1'b1;
   endsequence

   property p_gain;
      s_done(8'hc0, 1'b1) |-> s_settle ##0 (o_input_gain == an_q[2:1]);
   endproperty
   property p_apower;
      s_done(8'hc4, 1'b1) |-> s_settle ##0 (o_analog_power_on == pw_q[0]);
   endproperty
   property p_result_bits;
      s_done(8'ha8, 1'b0) |-> (o_prdata[31:1] == 31'h0);
   endproperty
   property p_slverr;
      o_pready |-> (o_pslverr == !f_mapped(i_paddr));
   endproperty
   property p_pready_pulse;
      o_pready |=> !o_pready;
   endproperty
   property p_dclk_park;
      !o_digital_power_on && ($past(o_digital_power_on) == 1'b0) |-> o_digital_clk;
   endproperty
   property p_dclk_start;
      $rose(o_digital_power_on) |-> o_digital_clk;
   endproperty
   property p_osc_run;
      (i_clk_en && !i_clock_out_ctl_pin) [*2] |-> o_osc_run;
   endproperty
   property p_clkout_low;
      (i_clk_en && i_clock_out_ctl_pin) [*2] |-> !o_clock_out_pin;
   endproperty

   a_gain: assert property (p_gain) else $error("gain pins differ from write");
   a_apower: assert property (p_apower) else $error("analog power pin wrong");
   a_result_bits: assert property (p_result_bits) else $error("unused bits set");
   a_slverr: assert property (p_slverr) else $error("slave error wrong");
   a_pready_pulse: assert property (p_pready_pulse) else $error("ready too long");
   a_dclk_park: assert property (p_dclk_park) else $error("digital clock not parked");
   a_dclk_start: assert property (p_dclk_start) else $error("digital clock start low");
   a_osc_run: assert property (p_osc_run) else $error("oscillator stopped");
   a_clkout_low: assert property (p_clkout_low) else $error("clock out not low");
endmodule : crpt_top_props

bind crpt_top crpt_top_props u_crpt_top_props (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_clock_out_ctl_pin(i_clock_out_ctl_pin), .o_clock_out_pin(o_clock_out_pin),
   .o_osc_run(o_osc_run), .o_input_gain(o_input_gain), .o_analog_power_on(o_analog_power_on),
   .o_digital_power_on(o_digital_power_on), .o_digital_clk(o_digital_clk)
);

// [test/crc_power_test_regs_bench.sv]
// Self-checking bench for the CRC, power and test register block.
// Assumes it is the only APB master and keeps the clock enable high.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module crc_power_test_regs_bench import crpt_pkg::*;;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, lerr;
   logic ctl, tick, found, chi, clo, clkout, oscrun, apw, dpw, dclk;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [19:0] probe;
   logic [1:0] gain;
   logic [2:0] monsel;
   logic [4:0] tout;
   logic [15:0] acc_exp, sv;
   crpt_det_src_t det;
   int fails = 0;
   int checks_done = 0;

   crpt_top #(.FIFO_DEPTH(16), .CRC_POLY(16'h1021)) u_crpt_top (
      .i_ref_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_clock_out_ctl_pin(ctl), .i_xtal_tick(tick),
      .i_internal_monitor(probe), .i_block_id_found(found), .i_block_id_code_hi(chi),
      .i_block_id_code_lo(clo), .o_clock_out_pin(clkout), .o_osc_run(oscrun),
      .o_input_gain(gain), .o_monitor_sel(monsel), .o_detector_source(det),
      .o_analog_power_on(apw), .o_digital_power_on(dpw), .o_digital_clk(dclk),
      .o_test_out(tout));

   // 40 MHz reference clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // One APB transfer; request held until ready is seen at a rising edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         fails++;
         end_of_test();
      end
      q = prdata;
      lerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reference CRC step, MSB first, no final inversion
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
      return c;
   endfunction : crc8

   // Data bytes go in 25 cycles apart, which covers the 620 ns minimum
   task automatic feed(input logic [7:0] b);
      apb(8'ha4, 1'b1, {24'h0, b});
      acc_exp = crc8(acc_exp, b);
      repeat (25) @(posedge clk);
   endtask : feed

   task automatic chk_acc();
      apb(8'hac, 1'b0, 32'h0);
      sv[15:8] = q[7:0];
      apb(8'hb0, 1'b0, 32'h0);
      sv[7:0] = q[7:0];
      `CHK("accum", acc_exp, sv)
   endtask : chk_acc

   task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
      apb(a, 1'b1, {24'h0, d});
      repeat (2) @(posedge clk);
   endtask : wr_settle

   initial begin
      logic [7:0] codes [4];
      crpt_det_src_t dx [4];
      int e, x;
      logic prev;
      codes = '{8'h00, 8'h01, 8'h40, 8'h41};
      dx = '{CRPT_DET_COMPOSITE, CRPT_DET_TEST_ANALOG, CRPT_DET_TEST_DIGITAL,
             CRPT_DET_TEST_DIGITAL};
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; ctl = 1'b0; tick = 1'b1; probe = 20'h5a3c9; found = 1'b0;
      chi = 1'b0; clo = 1'b0; acc_exp = 16'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Reset values, write-only read, unmapped address
      apb(8'ha8, 1'b0, 32'h0);
      `CHK("result", 32'h0, q)
      chk_acc();
      apb(8'hc0, 1'b0, 32'h0);
      `CHK("wo read", 32'h0, q)
      apb(8'h04, 1'b0, 32'h0);
      `CHK("unmapped", 1'b1, lerr)
      // Preload, then a group with its own check appended must pass
      apb(8'hac, 1'b1, 32'h12);
      apb(8'hb0, 1'b1, 32'h34);
      acc_exp = 16'h1234;
      chk_acc();
      apb(8'ha0, 1'b1, 32'he1);
      acc_exp = 16'h0;
      for (int i = 0; i < 4; i++) feed(8'h31 + 8'(i));
      chk_acc();
      repeat (48) @(posedge clk);
      apb(8'ha8, 1'b0, 32'h0);
      `CHK("result", {31'h0, acc_exp != 16'h0}, q)
      x = acc_exp;
      feed(8'(x >> 8));
      feed(8'(x));
      repeat (48) @(posedge clk);
      apb(8'ha8, 1'b0, 32'h0);
      `CHK("result", 32'h0, q)
      // Pause a long group, run a short one, resume
      apb(8'ha0, 1'b1, 32'hf1);
      acc_exp = 16'h0;
      feed(8'ha5);
      feed(8'h5a);
      chk_acc();
      x = sv;
      apb(8'ha0, 1'b1, 32'he1);
      acc_exp = 16'h0;
      feed(8'h01);
      chk_acc();
      apb(8'hac, 1'b1, 32'(x >> 8));
      apb(8'hb0, 1'b1, 32'(x & 255));
      acc_exp = 16'(x);
      feed(8'hc3);
      chk_acc();
      // Analog controls
      for (int g = 0; g < 4; g++) begin
         wr_settle(8'hc0, 8'(g << 1));
         `CHK("gain", 2'(g), gain)
         wr_settle(8'hc0, 8'(((g == 3) ? 7 : g * 2 + 1) << 3));
         `CHK("monitor", 3'((g == 3) ? 7 : g * 2 + 1), monsel)
         wr_settle(8'hc0, codes[g]);
         `CHK("detector", dx[g], det)
      end
      wr_settle(8'hc0, 8'h00);
      // Power bits and divided clock with the control pin low, then oscillator hold and stop with it high
      wr_settle(8'hc4, 8'h03);
      `CHK("power", 2'b11, {apw, dpw})
      wr_settle(8'hc4, 8'h00);
      `CHK("power off", 3'b001, {apw, dpw, dclk})
      for (int k = 0; k < 8; k++) begin
         wr_settle(8'hc4, 8'(k << 4));
         e = 0;
         prev = clkout;
         repeat (512) begin
            @(posedge clk);
            e += int'(clkout && !prev);
            prev = clkout;
         end
         x = 512 >> (k + 1);
         `CHK("clkout rate", 1'b1, (e >= x - 1 && e <= x + 1))
         `CHK("osc", 1'b1, oscrun)
      end
      ctl <= 1'b1;
      wr_settle(8'hc4, 8'h04);
      repeat (8) @(posedge clk);
      `CHK("osc held", 2'b10, {oscrun, clkout})
      wr_settle(8'hc4, 8'h00);
      `CHK("osc stop", 2'b00, {oscrun, clkout})
      ctl <= 1'b0;
      // Test output selection
      apb(8'h3c, 1'b1, 32'h15);
      for (int c = 0; c < 8; c++) begin
         wr_settle(8'hc8, 8'(c << 5));
         if (c == 0 || c == 5 || c == 6) `CHK("ext port", 5'h15, tout)
         else if (c < 5) `CHK("monitor set", 5'(probe >> (5 * c - 5)), tout)
      end
      wr_settle(8'hc8, 8'he0);
      for (int c = 0; c < 5; c++) begin
         found <= (c < 4);
         {chi, clo} <= 2'(c);
         repeat (2) @(posedge clk);
         `CHK("block id", {c < 4, 2'(c), 2'b00}, tout)
      end
      end_of_test();
   end
endmodule : crc_power_test_regs_bench
